// >>> rtl/csi_params.svh
// csi_params.svh: offsets, bit positions, reset values of the status block
// assumes inclusion by bare name from csi_sync and csi_status_irq
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH

// register offsets on the serial configuration port
`define CSI_ADDR_IEN   8'h4C
`define CSI_ADDR_LATCH 8'h50
`define CSI_ADDR_LIVE  8'h51
`define CSI_ADDR_CAL   8'h53

// source positions, shared by interrupt_enable_mask, latched_event_flags and momentary_condition_flags
`define CSI_BIT_SYNTH  5
`define CSI_BIT_JPLL   4
`define CSI_BIT_REF    3
`define CSI_BIT_HOLD   2
`define CSI_BIT_LOS1   1
`define CSI_BIT_LOS0   0
`define CSI_NSRC       6

// other fields
`define CSI_BIT_SEL    6
`define CSI_BIT_CAL    2
`define CSI_RAW_CAL    7
`define CSI_RAW_SEL    6

// reset values
`define CSI_IEN_RST    6'h00
// synchroniser: calibration running and reference present, so reset raises no false loss
`define CSI_SYNC_RST   8'h88
`define CSI_RDATA_RST  8'h00

`endif

// >>> rtl/csi_pkg.sv
// csi_pkg: state and carrier types of the clock status block
// assumes no other package; nothing is imported anywhere
package csi_pkg;

    // register request from the serial port front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csi_reg_req_t;

    // two-flop synchroniser state
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } csi_sync_t;

    // one sticky event flag
    typedef struct packed {
        logic flag;
    } csi_sticky_t;

    // top-level state
    typedef struct packed {
        logic [5:0] ien;
        logic       irq_n;
        logic [7:0] rdata;
        logic       rvalid;
    } csi_top_t;

endpackage

// >>> rtl/csi_sync.sv
// csi_sync: two-flop synchroniser for the eight detector levels
// assumes detector levels are asynchronous to the system clock
`timescale 1ns/1ps
`include "csi_params.svh"

module csi_sync (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    // levels
    input  wire logic [7:0] raw_i,
    output logic      [7:0] sync_o
);

    csi_pkg::csi_sync_t st_q;
    csi_pkg::csi_sync_t st_d;

    // first stage only feeds the second stage
    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            st_d.s1 = raw_i;
            st_d.s2 = st_q.s1;
        end
    end

    // calibration and reference-present levels reset high, others low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= {`CSI_SYNC_RST, `CSI_SYNC_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.s2;

endmodule // csi_sync

// >>> rtl/csi_sticky.sv
// csi_sticky: one sticky event flag, set by hardware, cleared by software
// assumes set and clear are both on the system clock
`timescale 1ns/1ps

module csi_sticky (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    // control
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);

    csi_pkg::csi_sticky_t st_q;
    csi_pkg::csi_sticky_t st_d;

    // set beats clear so an event in the clear cycle survives
    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            st_d.flag = set_i | (st_q.flag & ~clr_i);
        end
    end

    // no event recorded after reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

endmodule // csi_sticky

// >>> rtl/csi_status_irq.sv
// csi_status_irq: status registers and active-low interrupt of the clock conditioner
// assumes the serial port front end presents decoded requests on the system clock,
// and that detector levels arrive asynchronously from the analog side
//
// Behaviour
// - synthesizer unlock enable set: latched synthesizer unlock pulls interrupt low
// - jitter pll unlock enable set: latched unlock pulls interrupt low
// - each input has own loss enable; latched loss pulls interrupt low
// - reference enable set: change of latched reference pulls interrupt low
// - holdover enable set: latched holdover pulls interrupt low; resets to 0
// - latched synthesizer unlock reads 0 after any event, 1 otherwise
// - write 1 clears latched synthesizer unlock and its interrupt
// - latched jitter pll unlock reads 0 after any event, 1 otherwise
// - write 1 clears latched jitter pll unlock and its interrupt
// - latched input loss reads 0 after event; write 1 clears it
// - latched reference reads 0 if reference lost since last clear
// - write 1 clears latched reference and its interrupt
// - latched holdover reads 0 after holdover entered, 1 otherwise
// - write 1 clears latched holdover and its interrupt
// - selection bit shows which input the selector uses, 0 or 1
// - live synthesizer unlock bit reads 0 during loss, read-only
// - live jitter pll unlock bit reads 0 during loss, read-only
// - live input bit reads 0 during loss of signal, 1 when active
// - live reference bit reads 1 when reference present on selected input
// - live holdover bit reads 0 in holdover, 1 when locking
// - calibration bit resets to 1, reads 1 running, 0 when done
`timescale 1ns/1ps
`include "csi_params.svh"

module csi_status_irq (
    // clock, reset, enable
    input  wire logic                SYS_CLK_I,
    input  wire logic                RST_B_I,
    input  wire logic                CE_I,
    // register request from serial port
    input  wire csi_pkg::csi_reg_req_t REG_REQ_I,
    // register answer
    output logic               [7:0] REG_RDATA_O,
    output logic                     REG_RVALID_O,
    // detector levels
    input  wire logic                SYNTH_UNLOCK_I,
    input  wire logic                JITTER_PLL_UNLOCK_I,
    input  wire logic                REFERENCE_PRESENT_I,
    input  wire logic                HOLDOVER_I,
    input  wire logic          [1:0] INPUT_LOS_I,
    input  wire logic                ACTIVE_INPUT_I,
    input  wire logic                SYNTH_CAL_RUNNING_I,
    // interrupt toward host
    output logic                     IRQ_OUT_N_O
);

    // address match, used by write and read decode
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // packed raw pin levels and synchronised detector levels
    logic [7:0] raw;
    logic [7:0] syn;
    // active-high loss conditions, one per source
    logic [5:0] cond;
    // sticky event flags, 1 = event since last clear
    logic [5:0] ev;
    // write-one-clear strobes
    logic [5:0] clr;
    // decoded strobes
    logic       wr_ien;
    logic       wr_latch;
    logic       rd_any;
    // assembled read views
    logic [7:0] view_ien;
    logic [7:0] view_latch;
    logic [7:0] view_live;
    logic [7:0] view_cal;
    logic [7:0] rd_mux;

    csi_pkg::csi_top_t st_q;
    csi_pkg::csi_top_t st_d;

    // pack pins so one synchroniser covers all of them
    always_comb begin
        raw                 = 8'h00;
        raw[`CSI_RAW_CAL]   = SYNTH_CAL_RUNNING_I;
        raw[`CSI_RAW_SEL]   = ACTIVE_INPUT_I;
        raw[`CSI_BIT_SYNTH] = SYNTH_UNLOCK_I;
        raw[`CSI_BIT_JPLL]  = JITTER_PLL_UNLOCK_I;
        raw[`CSI_BIT_REF]   = REFERENCE_PRESENT_I;
        raw[`CSI_BIT_HOLD]  = HOLDOVER_I;
        raw[`CSI_BIT_LOS1]  = INPUT_LOS_I[1];
        raw[`CSI_BIT_LOS0]  = INPUT_LOS_I[0];
    end

    // pins are asynchronous, two flops before any use
    csi_sync u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .ce_i    (CE_I),
        .raw_i   (raw),
        .sync_o  (syn)
    );

    // loss conditions in active-high form; reference counts when absent
    always_comb begin
        cond                 = syn[5:0];
        cond[`CSI_BIT_REF]   = ~syn[`CSI_BIT_REF];
    end

    // request decode
    always_comb begin
        wr_ien   = REG_REQ_I.wr & addr_hit(REG_REQ_I.addr, `CSI_ADDR_IEN);
        wr_latch = REG_REQ_I.wr & addr_hit(REG_REQ_I.addr, `CSI_ADDR_LATCH);
        rd_any   = REG_REQ_I.rd;
    end

    // only ones written to latched_event_flags clear; zeros leave flags alone
    assign clr = wr_latch ? REG_REQ_I.wdata[5:0] : 6'h00;

    // one sticky flag per source; a live condition re-sets at once
    genvar gi;
    generate
        for (gi = 0; gi < `CSI_NSRC; gi = gi + 1) begin : g_src
            csi_sticky u_sticky (
                .clk_i   (SYS_CLK_I),
                .rst_b_i (RST_B_I),
                .ce_i    (CE_I),
                .set_i   (cond[gi]),
                .clr_i   (clr[gi]),
                .flag_o  (ev[gi])
            );
        end
    endgenerate

    // read views; reserved bits read zero
    always_comb begin
        view_ien               = {2'b00, st_q.ien};
        view_latch             = {2'b00, ~ev};
        view_live              = {1'b0, syn[`CSI_RAW_SEL], ~cond};
        view_cal               = 8'h00;
        view_cal[`CSI_BIT_CAL] = syn[`CSI_RAW_CAL];
    end

    // read mux; unmapped offsets answer zero
    always_comb begin
        if (addr_hit(REG_REQ_I.addr, `CSI_ADDR_IEN)) begin
            rd_mux = view_ien;
        end else if (addr_hit(REG_REQ_I.addr, `CSI_ADDR_LATCH)) begin
            rd_mux = view_latch;
        end else if (addr_hit(REG_REQ_I.addr, `CSI_ADDR_LIVE)) begin
            rd_mux = view_live;
        end else if (addr_hit(REG_REQ_I.addr, `CSI_ADDR_CAL)) begin
            rd_mux = view_cal;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // next state: enables, interrupt level, read answer
    always_comb begin
        st_d        = st_q;
        if (CE_I) begin
            st_d.rvalid = rd_any;
            if (rd_any) begin
                st_d.rdata = rd_mux;
            end
            if (wr_ien) begin
                st_d.ien = REG_REQ_I.wdata[5:0];
            end
            // low while any enabled flag is pending
            st_d.irq_n = ~|(ev & st_q.ien);
        end
    end

    // enables start disabled so no interrupt before software sets up
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q.ien    <= `CSI_IEN_RST;
            st_q.irq_n  <= 1'b1;
            st_q.rdata  <= `CSI_RDATA_RST;
            st_q.rvalid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign REG_RDATA_O  = st_q.rdata;
    assign REG_RVALID_O = st_q.rvalid;
    assign IRQ_OUT_N_O  = st_q.irq_n;

    // checks on the interrupt path and the register views
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    // enabled synthesizer flag pulls the pin low next cycle
    a_synth_irq_low: assert property (
        (CE_I && st_q.ien[`CSI_BIT_SYNTH] && ev[`CSI_BIT_SYNTH]) |=> !IRQ_OUT_N_O
    ) else $error("synth unlock did not assert interrupt");

    // enabled jitter pll flag pulls the pin low next cycle
    a_jpll_irq_low: assert property (
        (CE_I && st_q.ien[`CSI_BIT_JPLL] && ev[`CSI_BIT_JPLL]) |=> !IRQ_OUT_N_O
    ) else $error("jitter pll unlock did not assert interrupt");

    // each input loss flag, enabled, pulls the pin low
    a_los_irq_low: assert property (
        (CE_I && |(st_q.ien[1:0] & ev[1:0])) |=> !IRQ_OUT_N_O
    ) else $error("input loss did not assert interrupt");

    // reference loss, enabled, pulls the pin low
    a_ref_irq_low: assert property (
        (CE_I && st_q.ien[`CSI_BIT_REF] && ev[`CSI_BIT_REF]) |=> !IRQ_OUT_N_O
    ) else $error("reference change did not assert interrupt");

    // holdover, enabled, pulls the pin low
    a_hold_irq_low: assert property (
        (CE_I && st_q.ien[`CSI_BIT_HOLD] && ev[`CSI_BIT_HOLD]) |=> !IRQ_OUT_N_O
    ) else $error("holdover did not assert interrupt");

    // nothing enabled and pending: pin returns high
    a_irq_release: assert property (
        (CE_I && !(|(ev & st_q.ien))) |=> IRQ_OUT_N_O
    ) else $error("interrupt low with nothing pending");

    // a live synthesizer loss shows in the latched read
    a_synth_latch_set: assert property (
        (CE_I && cond[`CSI_BIT_SYNTH]) |=> !view_latch[`CSI_BIT_SYNTH]
    ) else $error("synth latch missed event");

    // write one clears synthesizer flag when condition is gone
    a_synth_w1c: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_SYNTH] && !cond[`CSI_BIT_SYNTH])
        |=> !ev[`CSI_BIT_SYNTH]
    ) else $error("synth latch not cleared by write one");

    // write one clears jitter pll flag when condition is gone
    a_jpll_w1c: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_JPLL] && !cond[`CSI_BIT_JPLL])
        |=> !ev[`CSI_BIT_JPLL]
    ) else $error("jitter pll latch not cleared by write one");

    // a zero written leaves a pending flag in place
    a_zero_keeps: assert property (
        (CE_I && ev[`CSI_BIT_HOLD] && !clr[`CSI_BIT_HOLD]) |=> ev[`CSI_BIT_HOLD]
    ) else $error("holdover latch lost without write one");

    // live read of momentary_condition_flags returns inverted loss levels and selection
    a_live_read: assert property (
        (CE_I && rd_any && addr_hit(REG_REQ_I.addr, `CSI_ADDR_LIVE))
        |=> REG_RVALID_O && (REG_RDATA_O[5:0] == ~$past(cond))
            && (REG_RDATA_O[`CSI_BIT_SEL] == $past(syn[`CSI_RAW_SEL]))
    ) else $error("live status read mismatch");

    // calibration read follows the synchronised level
    a_cal_read: assert property (
        (CE_I && rd_any && addr_hit(REG_REQ_I.addr, `CSI_ADDR_CAL))
        |=> REG_RDATA_O == {5'h00, $past(syn[`CSI_RAW_CAL]), 2'b00}
    ) else $error("calibration status read mismatch");

    // jitter pll loss shows in the latched read
    a_jpll_latch_set: assert property (
        (CE_I && cond[`CSI_BIT_JPLL]) |=> !view_latch[`CSI_BIT_JPLL]
    ) else $error("jitter pll latch missed event");

    // loss on the first input shows in its latched bit
    a_los0_latch_set: assert property (
        (CE_I && cond[`CSI_BIT_LOS0]) |=> !view_latch[`CSI_BIT_LOS0]
    ) else $error("input 0 loss latch missed event");

    // loss on the second input shows in its latched bit
    a_los1_latch_set: assert property (
        (CE_I && cond[`CSI_BIT_LOS1]) |=> !view_latch[`CSI_BIT_LOS1]
    ) else $error("input 1 loss latch missed event");

    // absent reference, taken from the synchronised level, reads 0 in the latch
    a_ref_latch_set: assert property (
        (CE_I && !syn[`CSI_BIT_REF]) |=> !view_latch[`CSI_BIT_REF]
    ) else $error("reference latch missed loss");

    // holdover entry shows in the latched read
    a_hold_latch_set: assert property (
        (CE_I && syn[`CSI_BIT_HOLD]) |=> !view_latch[`CSI_BIT_HOLD]
    ) else $error("holdover latch missed entry");

    // write one on input 0 loss with the signal back: bit reads 1 again
    a_los_w1c: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_LOS0] && !syn[`CSI_BIT_LOS0])
        |=> view_latch[`CSI_BIT_LOS0]
    ) else $error("input loss latch not cleared by write one");

    // write one on the reference latch with reference present: bit reads 1 again
    a_ref_w1c: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_REF] && syn[`CSI_BIT_REF])
        |=> view_latch[`CSI_BIT_REF]
    ) else $error("reference latch not cleared by write one");

    // write one on the holdover latch out of holdover: bit reads 1 again
    a_hold_w1c: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_HOLD] && !syn[`CSI_BIT_HOLD])
        |=> view_latch[`CSI_BIT_HOLD]
    ) else $error("holdover latch not cleared by write one");

    // a clear that meets a live condition leaves the flag set
    a_set_wins: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_SYNTH] && cond[`CSI_BIT_SYNTH])
        |=> ev[`CSI_BIT_SYNTH]
    ) else $error("clear beat a live synth event");

    // clearing the only enabled pending source releases the pin two cycles later
    a_jpll_clr_release: assert property (
        (CE_I && wr_latch && REG_REQ_I.wdata[`CSI_BIT_JPLL] && (cond == 6'h00)
            && ((ev & st_q.ien) == (6'h01 << `CSI_BIT_JPLL))) ##1 CE_I |=> IRQ_OUT_N_O
    ) else $error("interrupt held after jitter pll clear");

    // enable register takes the written low six bits
    a_ien_write: assert property (
        (CE_I && wr_ien) |=> (st_q.ien == $past(REG_REQ_I.wdata[5:0]))
    ) else $error("enable write not taken");

    // writes elsewhere leave the enables alone; status is read-only
    a_ro_write: assert property (
        (CE_I && REG_REQ_I.wr && !wr_ien) |=> $stable(st_q.ien)
    ) else $error("enables changed by a foreign write");

    // latched read returns the inverted flags
    a_latch_read: assert property (
        (CE_I && rd_any && addr_hit(REG_REQ_I.addr, `CSI_ADDR_LATCH))
        |=> REG_RVALID_O && (REG_RDATA_O == {2'b00, ~$past(ev)})
    ) else $error("latched status read mismatch");

    // no read taken, no answer
    a_rvalid_idle: assert property (
        (CE_I && !rd_any) |=> !REG_RVALID_O
    ) else $error("read answer without request");

    // read data stands until the next taken read
    a_rdata_hold: assert property (
        (CE_I && !rd_any) |=> $stable(REG_RDATA_O)
    ) else $error("read data moved without a read");

    // a frozen clock enable holds the interrupt level
    a_ce_hold: assert property (
        !CE_I |=> $stable(IRQ_OUT_N_O)
    ) else $error("interrupt moved while clock enable low");

endmodule // csi_status_irq

// >>> bench/csi_host_model.sv
// csi_host_model: host side of the register port, one byte per request
// assumes one system clock; expected read data waits in exp_q for the bench monitor
`timescale 1ns/1ps

module csi_host_model (
    // clock
    input  wire logic             clk_i,
    // request toward the block
    output csi_pkg::csi_reg_req_t req_o
);
    logic [7:0] exp_q[$];  // expected read answers, oldest first

    // idle from time zero
    initial req_o = '0;

    // held for one clock edge; idle lines carry inverted junk, never the last value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask

    // a 1 in a latched position asks for that latch to clear
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'h1, a, d);
    endtask

    // expectation noted before the request goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'h0, a, 8'h00);
    endtask
endmodule // csi_host_model

// >>> bench/tb_top.sv
// tb_top: self-checking bench for csi_status_irq
// assumes csi_pkg compiled first; host model drives the register port
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); end end

module tb_top;
    logic                  sys_clk = 1'h0;
    logic                  rst_b   = 1'h0;
    logic                  ce      = 1'h1;
    logic [5:0]            cond    = 6'h00;  // condition per source, bit order of the map
    logic                  sel     = 1'h0;
    logic                  cal     = 1'h1;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  irq_n;
    logic [7:0]            exp_d;
    logic [5:0]            m;
    logic [31:0]           r;
    csi_pkg::csi_reg_req_t req;
    int                    error_cnt  = 0;
    int                    num_checks = 0;
    int                    cyc        = 0;

    // 250 MHz
    always #2 sys_clk = ~sys_clk;

    // host side
    csi_host_model i_host (.clk_i(sys_clk), .req_o(req));

    // reference is a presence level, so its condition is the inverse
    csi_status_irq i_csi_status_irq (
        .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CE_I(ce), .REG_REQ_I(req),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .SYNTH_UNLOCK_I(cond[5]), .JITTER_PLL_UNLOCK_I(cond[4]), .REFERENCE_PRESENT_I(~cond[3]),
        .HOLDOVER_I(cond[2]), .INPUT_LOS_I(cond[1:0]), .ACTIVE_INPUT_I(sel),
        .SYNTH_CAL_RUNNING_I(cal), .IRQ_OUT_N_O(irq_n)
    );

    // verdict, reached from the main sequence and from the timeout
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // longer than pin->sync->flag->irq, so levels have landed
    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    // sampled mid-cycle, away from the launching edge
    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        `CHK(irq_n, e, "interrupt level")
    endtask

    // read answers matched in order against the host's notes
    always @(negedge sys_clk) begin
        if (rvalid === 1'h1) begin
            if (i_host.exp_q.size() == 0) begin
                `CHK(1'h1, 1'h0, "unexpected read answer")
            end else begin
                exp_d = i_host.exp_q.pop_front();
                `CHK(rdata, exp_d, "read data")
            end
        end
    end

    // hang guard; whole run is well under a thousand cycles per source
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            print_verdict();
        end
    end

    // main sequence
    initial begin
        void'($urandom(9));
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'h1;
        i_host.rd(8'h4C, 8'h00);
        i_host.rd(8'h50, 8'h3F);
        i_host.rd(8'h53, 8'h04);
        chk_irq(1'h1);
        // each source alone: disabled, enabled, clear refused while present, clear
        for (int i = 0; i < 6; i++) begin
            m = 6'h01 << i;
            @(posedge sys_clk) cond <= m;
            settle();
            chk_irq(1'h1);
            i_host.rd(8'h51, {1'h0, sel, ~m});
            i_host.wr(8'h4C, {2'h0, m});
            settle();
            chk_irq(1'h0);
            i_host.wr(8'h50, 8'h00);
            i_host.wr(8'h50, {2'h0, m});
            i_host.rd(8'h50, {2'h0, ~m});
            chk_irq(1'h0);
            @(posedge sys_clk) cond <= 6'h00;
            settle();
            i_host.wr(8'h50, {2'h0, m});
            settle();
            chk_irq(1'h1);
            i_host.rd(8'h50, 8'h3F);
        end
        // two pending sources: irq holds after one is cleared, releases once the other is masked
        i_host.wr(8'h4C, 8'h3F);
        @(posedge sys_clk) cond <= 6'h21;
        settle();
        @(posedge sys_clk) cond <= 6'h00;
        settle();
        i_host.wr(8'h50, 8'h20);
        settle();
        chk_irq(1'h0);
        i_host.wr(8'h4C, 8'h1E);
        settle();
        chk_irq(1'h1);
        i_host.wr(8'h50, 8'h01);
        i_host.wr(8'h4C, 8'h00);
        // clock enable low: a write is ignored
        @(posedge sys_clk) ce <= 1'h0;
        i_host.wr(8'h4C, 8'h3F);
        @(posedge sys_clk) ce <= 1'h1;
        i_host.rd(8'h4C, 8'h00);
        // random live levels, selection and calibration
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            @(posedge sys_clk);
            sel  <= r[6];
            cal  <= r[7];
            cond <= r[5:0];
            settle();
            i_host.rd(8'h51, {1'h0, sel, ~cond});
            i_host.rd(8'h53, {5'h00, cal, 2'h0});
        end
        // mid-run reset with flags pending: enables, latches and pin back to idle
        @(posedge sys_clk) cond <= 6'h00;
        i_host.wr(8'h4C, 8'h3F);
        @(posedge sys_clk) rst_b <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        chk_irq(1'h1);
        i_host.rd(8'h4C, 8'h00);
        i_host.rd(8'h50, 8'h3F);
        @(posedge sys_clk) cal <= 1'h0;
        settle();
        i_host.rd(8'h53, 8'h00);
        // refused places: unmapped read, write to read-only status
        i_host.rd(8'h52, 8'h00);
        i_host.wr(8'h51, 8'hFF);
        i_host.rd(8'h51, {1'h0, sel, ~cond});
        i_host.rd(8'h4C, 8'h00);
        settle();
        `CHK(i_host.exp_q.size(), 0, "answers missing")
        print_verdict();
    end
endmodule // tb_top
